// File: rtl/exc_pkg.sv
// constants, field layouts and state type shared by the exception vectoring unit
package exc_pkg;
  // ****************************************
  // vector table geometry
  // ****************************************
  localparam int          VEC_TABLE_BYTES = 1024;
  localparam int          VEC_COUNT       = 256;
  localparam int          CPU_VECTORS     = 64;
  localparam int          USER_VECTORS    = 192;
  localparam logic [31:0] RESET_SP_OFFSET = 32'h0000_0000;
  localparam logic [31:0] RESET_PC_OFFSET = 32'h0000_0004;

  // ****************************************
  // vector numbers
  // ****************************************
  localparam logic [7:0] VEC_BUS_ERR    = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR   = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV   = 8'h05;
  localparam logic [7:0] VEC_BOUNDS     = 8'h06;
  localparam logic [7:0] VEC_COND_TRAP  = 8'h07;
  localparam logic [7:0] VEC_PRIV       = 8'h08;
  localparam logic [7:0] VEC_TRACE      = 8'h09;
  localparam logic [7:0] VEC_LINE_A     = 8'h0A;
  localparam logic [7:0] VEC_LINE_F     = 8'h0B;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h0C;
  localparam logic [7:0] VEC_COPRO_PROT = 8'h0D;
  localparam logic [7:0] VEC_FORMAT_ERR = 8'h0E;
  localparam logic [7:0] VEC_UNINIT_INT = 8'h0F;
  localparam logic [7:0] VEC_SPURIOUS   = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE  = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE  = 8'h20;
  localparam logic [7:0] VEC_COPRO_LO   = 8'h30;
  localparam logic [7:0] VEC_COPRO_HI   = 8'h3A;
  localparam logic [7:0] VEC_USER_LO    = 8'h40;

  // ****************************************
  // pending cause indices, lowest index wins
  // ****************************************
  localparam int NUM_CAUSES  = 13;
  localparam int C_BUS_ERR   = 0;
  localparam int C_ADDR_ERR  = 1;
  localparam int C_ILLEGAL   = 2;
  localparam int C_ZERO_DIV  = 3;
  localparam int C_BOUNDS    = 4;
  localparam int C_COND_TRAP = 5;
  localparam int C_PRIV      = 6;
  localparam int C_TRACE     = 7;
  localparam int C_LINE_A    = 8;
  localparam int C_LINE_F    = 9;
  localparam int C_BREAKPOINT_INSTRUCTION      = 10;
  localparam int C_FORMAT    = 11;
  localparam int C_TRAP      = 12;

  // ****************************************
  // address spaces, status word fields
  // ****************************************
  localparam logic [3:0] SPACE_SUP_DATA = 4'h5;
  localparam logic [3:0] SPACE_SUP_PROG = 4'h6;
  localparam logic [3:0] SPACE_CPU      = 4'hF;
  localparam int         SR_T1_BIT      = 15;
  localparam int         SR_T0_BIT      = 14;
  localparam int         SR_S_BIT       = 13;
  localparam int         SR_MASK_LSB    = 8;
  localparam logic [2:0] MASK_RESET     = 3'h7;
  localparam logic [2:0] LEVEL_NMI      = 3'h7;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_VBR    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SSP    = 12'h008;
  localparam logic [31:0] VBR_RESET   = 32'h0000_0000;
  localparam logic [31:0] SSP_RESET   = 32'h0000_0000;
  localparam int          STAT_BUSY   = 8;
  localparam int          STAT_STOP   = 9;
  localparam int          STAT_PEND   = 16;

  typedef enum logic [2:0] {
    ST_RST_SP, ST_RST_PC, ST_IDLE, ST_IACK, ST_PUSH_PC, ST_PUSH_SR, ST_FETCH
  } exc_state_type;
endpackage

// File: rtl/cpu_exception_vectoring.sv
// exception vectoring unit: causes, state change, vector number, stack frame, vector fetch
//
// Overview of operation
// - vector table is 1024 bytes, 256 entries, based at vector_table_base.
// - first 64 vectors processor defined, remaining 192 for user interrupts.
// - each entry one long word; reset entry is stack pointer then program counter.
// - reset entries read from supervisor program space, all others supervisor data.
// - only reset entries fixed; afterwards table follows the software base register.
// - reset uses vector 0 at 000 for stack, vector 1 at 004 for pc.
// - vector 13 and vectors 48 to 58 reserved for coprocessor.
// - vectors 14 and 15 used for format error and uninitialized interrupt; the code only makes 14, never 15.
// - autovectored levels 1 to 7 map to vectors 25 to 31.
// - software exception variants 0 to 15 map to vectors 32 to 47.
// - vectors 64 to 255 serve externally supplied interrupt vector numbers.
// - vector numbers are 8 bits, from a peripheral or generated inside.
// - vector address is base register plus vector number times four.
// - trap, bounds, overflow, return, breakpoint, divide instructions raise exceptions.
// - illegal opcode, odd fetch, odd operand access, privilege violation raise exceptions.
// - copy status word, then set supervisor bit and clear both trace bits.
// - reset and interrupt exceptions also update the interrupt priority mask.
// - interrupt vector read by acknowledge cycle in cpu space F.
// - non-interrupt exceptions get their vector internally, no bus cycle.
// - push frame with saved status word and program counter on supervisor stack.
// - load fetched vector into program counter, then take next pending exception.
// - leave halt only on interrupt at or above set level; exceptions end loop mode.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cpu_exception_vectoring #(
  parameter int CAUSES = exc_pkg::NUM_CAUSES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [12:0] cause_pulse,
  input  wire logic [3:0]  trap_variant,
  input  wire logic [2:0]  irq_level,
  input  wire logic        low_power_halt_instruction,
  input  wire logic [2:0]  halt_wake_level,
  input  wire logic [15:0] sr_in,
  input  wire logic [31:0] pc_in,
  output logic      [15:0] sr_out,
  output logic             sr_load,
  output logic      [31:0] pc_out,
  output logic             pc_load,
  output logic             loop_exit,
  output logic             halted,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [3:0]  mem_space,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic        mem_avec,
  input  wire logic [31:0] mem_rdata
);
  // ****************************************
  // state
  // ****************************************
  exc_pkg::exc_state_type state_r;
  logic [31:0]       vector_table_base_r;
  logic [31:0]       ssp_r;
  logic [CAUSES-1:0] pend_r;
  logic [CAUSES-1:0] pend_clr;
  logic [3:0]        trap_num_r;
  logic [7:0]        vec_r;
  logic [15:0]       sr_copy_r;
  logic [31:0]       pc_copy_r;
  logic [2:0]        irq_lvl_r;
  logic [2:0]        wake_lvl_r;
  logic [7:0]        take_vec;
  logic              take_any;
  logic              irq_take;
  logic [15:0]       sr_nxt;
  logic [31:0]       vec_addr;
  logic              apb_wr;
  logic              apb_setup;

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;

  // ****************************************
  // register bus slave
  // ****************************************
  // one wait-free access: ready rises in the access cycle, read data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        case (paddr)
          exc_pkg::ADDR_VBR: prdata <= vector_table_base_r;
          exc_pkg::ADDR_SSP: prdata <= ssp_r;
          exc_pkg::ADDR_STATUS: begin
            prdata <= 32'h0000_0000;
            prdata[7:0] <= vec_r;
            prdata[exc_pkg::STAT_BUSY] <= (state_r != exc_pkg::ST_IDLE);
            prdata[exc_pkg::STAT_STOP] <= halted;
            prdata[exc_pkg::STAT_PEND +: CAUSES] <= pend_r;
          end
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1; // unmapped offset
          end
        endcase
      end
    end
  end

  // base register: software may move the table at any time, even per task
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_table_base_r <= exc_pkg::VBR_RESET;
    end else if (apb_wr && paddr == exc_pkg::ADDR_VBR) begin
      vector_table_base_r <= pwdata;
    end
  end

  // ****************************************
  // pending causes
  // ****************************************
  // one sticky bit per cause; a new pulse in the clearing cycle is kept
  genvar g;
  generate
    for (g = 0; g < CAUSES; g++) begin : g_pend
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_r[g] <= 1'b0;
        end else if (cause_pulse[g]) begin
          pend_r[g] <= 1'b1;
        end else if (pend_clr[g]) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // trap variant is caught with its pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_num_r <= 4'h0;
    end else if (cause_pulse[exc_pkg::C_TRAP]) begin
      trap_num_r <= trap_variant;
    end
  end

  // fixed priority pick, lowest index first; vector number made internally
  always_comb begin
    take_any = 1'b0;
    take_vec = 8'h00;
    pend_clr = '0;
    for (int i = CAUSES - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        take_any = 1'b1;
        pend_clr = '0;
        pend_clr[i] = 1'b1;
        case (i)
          exc_pkg::C_BUS_ERR:   take_vec = exc_pkg::VEC_BUS_ERR;
          exc_pkg::C_ADDR_ERR:  take_vec = exc_pkg::VEC_ADDR_ERR;
          exc_pkg::C_ILLEGAL:   take_vec = exc_pkg::VEC_ILLEGAL;
          exc_pkg::C_ZERO_DIV:  take_vec = exc_pkg::VEC_ZERO_DIV;
          exc_pkg::C_BOUNDS:    take_vec = exc_pkg::VEC_BOUNDS;
          exc_pkg::C_COND_TRAP: take_vec = exc_pkg::VEC_COND_TRAP;
          exc_pkg::C_PRIV:      take_vec = exc_pkg::VEC_PRIV;
          exc_pkg::C_TRACE:     take_vec = exc_pkg::VEC_TRACE;
          exc_pkg::C_LINE_A:    take_vec = exc_pkg::VEC_LINE_A;
          exc_pkg::C_LINE_F:    take_vec = exc_pkg::VEC_LINE_F;
          exc_pkg::C_BREAKPOINT_INSTRUCTION:      take_vec = exc_pkg::VEC_BREAKPOINT;
          exc_pkg::C_FORMAT:    take_vec = exc_pkg::VEC_FORMAT_ERR;
          default:              take_vec = exc_pkg::VEC_TRAP_BASE + {4'h0, trap_num_r};
        endcase
      end
    end
    if (state_r != exc_pkg::ST_IDLE || halted) begin
      pend_clr = '0; // a cause met while halted stays pending until it is served
    end
  end

  // level 7 cannot be masked; others must beat the current mask
  assign irq_take = (irq_level != 3'h0) &&
                    (irq_level > sr_in[exc_pkg::SR_MASK_LSB +: 3] || irq_level == exc_pkg::LEVEL_NMI);

  // new status word: supervisor on, tracing off
  always_comb begin
    sr_nxt = sr_in;
    sr_nxt[exc_pkg::SR_S_BIT]  = 1'b1;
    sr_nxt[exc_pkg::SR_T1_BIT] = 1'b0;
    sr_nxt[exc_pkg::SR_T0_BIT] = 1'b0;
  end

  // table entry address from base and vector number
  assign vec_addr = vector_table_base_r + {22'h000000, vec_r, 2'b00};

  // ****************************************
  // low-power halt
  // ****************************************
  // halt ends on a level at or above the wake level; reset ends it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted     <= 1'b0;
      wake_lvl_r <= 3'h7;
    end else if (low_power_halt_instruction && state_r == exc_pkg::ST_IDLE) begin
      halted     <= 1'b1;
      wake_lvl_r <= halt_wake_level;
    end else if (halted && irq_level != 3'h0 && irq_level >= wake_lvl_r) begin
      halted <= 1'b0;
    end
  end

  // ****************************************
  // exception sequencer
  // ****************************************
  // a request stands until acked; the issuing assignment wins over the drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= exc_pkg::ST_RST_SP;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_space <= 4'h0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      ssp_r     <= exc_pkg::SSP_RESET;
      vec_r     <= 8'h00;
      sr_copy_r <= 16'h0000;
      pc_copy_r <= 32'h0000_0000;
      irq_lvl_r <= 3'h0;
      sr_out    <= 16'h0000;
      sr_load   <= 1'b0;
      pc_out    <= 32'h0000_0000;
      pc_load   <= 1'b0;
      loop_exit <= 1'b0;
    end else begin
      sr_load   <= 1'b0;
      pc_load   <= 1'b0;
      loop_exit <= 1'b0;
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
      case (state_r)
        exc_pkg::ST_RST_SP: begin
          // reset entries sit at fixed offsets, not behind the base register
          mem_req   <= !mem_ack;
          mem_we    <= 1'b0;
          mem_space <= exc_pkg::SPACE_SUP_PROG;
          mem_addr  <= exc_pkg::RESET_SP_OFFSET;
          if (mem_req && mem_ack) begin
            ssp_r     <= mem_rdata;
            mem_req   <= 1'b1;
            mem_addr  <= exc_pkg::RESET_PC_OFFSET;
            state_r   <= exc_pkg::ST_RST_PC;
          end
        end
        exc_pkg::ST_RST_PC: begin
          if (mem_ack) begin
            pc_out  <= mem_rdata;
            pc_load <= 1'b1;
            sr_out  <= {2'b00, 1'b1, 2'b00, exc_pkg::MASK_RESET, 8'h00};
            sr_load <= 1'b1;
            state_r <= exc_pkg::ST_IDLE;
          end
        end
        exc_pkg::ST_IDLE: begin
          if (apb_wr && paddr == exc_pkg::ADDR_SSP) ssp_r <= pwdata; // only while idle
          if (take_any && !halted) begin
            sr_copy_r <= sr_in;
            pc_copy_r <= pc_in;
            sr_out    <= sr_nxt;
            sr_load   <= 1'b1;
            loop_exit <= 1'b1;
            vec_r     <= take_vec;
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_space <= exc_pkg::SPACE_SUP_DATA;
            mem_addr  <= ssp_r - 32'h0000_0004;
            mem_wdata <= pc_in;
            state_r   <= exc_pkg::ST_PUSH_PC;
          end else if (irq_take && !(halted && irq_level < wake_lvl_r)) begin
            sr_copy_r <= sr_in;
            pc_copy_r <= pc_in;
            sr_out    <= sr_nxt;
            sr_out[exc_pkg::SR_MASK_LSB +: 3] <= irq_level;
            sr_load   <= 1'b1;
            loop_exit <= 1'b1;
            irq_lvl_r <= irq_level;
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_space <= exc_pkg::SPACE_CPU;
            mem_addr  <= {28'hFFFFFFF, irq_level, 1'b1};
            state_r   <= exc_pkg::ST_IACK;
          end
        end
        exc_pkg::ST_IACK: begin
          if (mem_ack) begin
            // peripheral answers with a number, asks for the autovector, or faults
            if (mem_err) begin
              vec_r <= exc_pkg::VEC_SPURIOUS;
            end else if (mem_avec) begin
              vec_r <= exc_pkg::VEC_AUTO_BASE + {5'h00, irq_lvl_r};
            end else begin
              vec_r <= mem_rdata[7:0];
            end
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_space <= exc_pkg::SPACE_SUP_DATA;
            mem_addr  <= ssp_r - 32'h0000_0004;
            mem_wdata <= pc_copy_r;
            state_r   <= exc_pkg::ST_PUSH_PC;
          end
        end
        exc_pkg::ST_PUSH_PC: begin
          if (mem_ack) begin
            ssp_r     <= ssp_r - 32'h0000_0004;
            mem_req   <= 1'b1;
            mem_addr  <= ssp_r - 32'h0000_0008;
            mem_wdata <= {sr_copy_r, 4'h0, 2'b00, vec_r, 2'b00};
            state_r   <= exc_pkg::ST_PUSH_SR;
          end
        end
        exc_pkg::ST_PUSH_SR: begin
          if (mem_ack) begin
            ssp_r     <= ssp_r - 32'h0000_0004;
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_space <= exc_pkg::SPACE_SUP_DATA;
            mem_addr  <= vec_addr;
            state_r   <= exc_pkg::ST_FETCH;
          end
        end
        exc_pkg::ST_FETCH: begin
          if (mem_ack) begin
            pc_out  <= mem_rdata;
            pc_load <= 1'b1;
            state_r <= exc_pkg::ST_IDLE;
          end
        end
        default: state_r <= exc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  vec_address_a: assert property (state_r == exc_pkg::ST_FETCH && mem_req |->
    mem_addr == vector_table_base_r + {22'h000000, vec_r, 2'b00} && mem_space == exc_pkg::SPACE_SUP_DATA)
    else $error("vector fetch address wrong");

  reset_fetch_a: assert property (state_r == exc_pkg::ST_RST_SP && mem_req |->
    mem_addr == 32'h0000_0000 && mem_space == exc_pkg::SPACE_SUP_PROG && !mem_we)
    else $error("reset stack fetch wrong");

  iack_space_a: assert property (state_r == exc_pkg::ST_IACK && mem_req |->
    mem_space == 4'hF && !mem_we)
    else $error("acknowledge cycle not in cpu space");

  sr_change_a: assert property (loop_exit |->
    sr_load && sr_out[exc_pkg::SR_S_BIT] && !sr_out[exc_pkg::SR_T1_BIT] && !sr_out[exc_pkg::SR_T0_BIT])
    else $error("status change wrong");

  irq_mask_a: assert property (state_r == exc_pkg::ST_IDLE ##1 state_r == exc_pkg::ST_IACK |->
    sr_out[exc_pkg::SR_MASK_LSB +: 3] == irq_lvl_r && $past(irq_level) == irq_lvl_r)
    else $error("interrupt mask not updated");

  pc_load_a: assert property (state_r == exc_pkg::ST_FETCH && mem_req && mem_ack |=>
    pc_load && pc_out == $past(mem_rdata) && state_r == exc_pkg::ST_IDLE)
    else $error("vector not loaded");

  halt_hold_a: assert property (halted && irq_level < wake_lvl_r && !low_power_halt_instruction |=>
    halted)
    else $error("halt left too early");

  autovector_a: assert property (state_r == exc_pkg::ST_IACK && mem_ack && !mem_err && mem_avec |=>
    vec_r == 8'd24 + {5'h00, irq_lvl_r})
    else $error("autovector number wrong");

  frame_order_a: assert property (state_r == exc_pkg::ST_PUSH_PC && mem_ack |=>
    state_r == exc_pkg::ST_PUSH_SR && mem_addr == ssp_r - 32'h0000_0004 && mem_we)
    else $error("frame push order wrong");

  copro_vec_free_a: assert property (loop_exit && state_r == exc_pkg::ST_PUSH_PC |->
    vec_r != exc_pkg::VEC_COPRO_PROT && (vec_r < exc_pkg::VEC_COPRO_LO || vec_r > exc_pkg::VEC_COPRO_HI))
    else $error("reserved coprocessor vector made internally");
endmodule

// File: tb/vec_bus_model.sv
// bus partner: memory with reset entries and vector table, plus an interrupting peripheral
`timescale 1ns/1ps
module vec_bus_model #(
  parameter logic [31:0] SP_INIT = 32'h0000_8000,
  parameter logic [31:0] PC_INIT = 32'h0000_0400
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [3:0]  mem_space,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  delay,
  input  wire logic [1:0]  iack_mode,
  input  wire logic [7:0]  iack_vec,
  output logic             mem_ack,
  output logic             mem_err,
  output logic             mem_avec,
  output logic      [31:0] mem_rdata,
  output logic      [3:0]  rd_space,
  output logic      [31:0] wr_prev,
  output logic      [31:0] wr_last
);
  // ****************************************
  // slave-paced answer
  // ****************************************
  logic [1:0] wait_r;

  // answer after a programmable wait; read data flips while idle so stale values never match by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r    <= 2'h0;
      mem_ack   <= 1'h0;
      mem_err   <= 1'h0;
      mem_avec  <= 1'h0;
      mem_rdata <= 32'h0;
      rd_space  <= 4'h0;
      wr_prev   <= 32'h0;
      wr_last   <= 32'h0;
    end else if (mem_req && !mem_ack && wait_r == delay) begin
      wait_r   <= 2'h0;
      mem_ack  <= 1'h1;
      mem_err  <= mem_space == 4'hF && iack_mode == 2'h2;
      mem_avec <= mem_space == 4'hF && iack_mode == 2'h1;
      if (mem_we) begin
        wr_prev <= wr_last;
        wr_last <= mem_wdata;
      end else begin
        rd_space <= mem_space;
        if (mem_space == 4'hF)
          mem_rdata <= {24'h0, iack_vec};
        else if (mem_space == 4'h6)
          mem_rdata <= mem_addr[2] ? PC_INIT : SP_INIT;
        else
          mem_rdata <= mem_addr + 32'h0100_0000; // table entry reads back its own address plus 0x0100_0000
      end
    end else begin
      wait_r    <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      mem_ack   <= 1'h0;
      mem_err   <= 1'h0;
      mem_avec  <= 1'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// File: tb/cpu_exception_vectoring_bench.sv
// self-checking bench for the exception vectoring unit
`timescale 1ns/1ps
module cpu_exception_vectoring_bench;
  localparam logic [31:0] SP_INIT = 32'h0000_8000;
  localparam logic [31:0] PC_INIT = 32'h0000_0400;
  localparam logic [7:0]  VECS [13] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                        8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h2F};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, low_power_halt_instruction;
  logic        sr_load, pc_load, loop_exit, halted, mem_req, mem_we, mem_ack, mem_err, mem_avec;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pc_in, pc_out, mem_addr, mem_wdata, mem_rdata, wr_prev, wr_last;
  logic [31:0] q, ssp_exp, vector_table_base;
  logic [12:0] cause_pulse;
  logic [3:0]  trap_variant, mem_space, rd_space;
  logic [2:0]  irq_level, halt_wake_level;
  logic [15:0] sr_in, sr_out;
  logic [1:0]  delay, iack_mode;
  logic [7:0]  iack_vec;
  int          failures, cmp_count, n;

  cpu_exception_vectoring dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cause_pulse(cause_pulse),
    .trap_variant(trap_variant), .irq_level(irq_level), .low_power_halt_instruction(low_power_halt_instruction),
    .halt_wake_level(halt_wake_level), .sr_in(sr_in), .pc_in(pc_in), .sr_out(sr_out), .sr_load(sr_load),
    .pc_out(pc_out), .pc_load(pc_load), .loop_exit(loop_exit), .halted(halted), .mem_req(mem_req),
    .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_avec(mem_avec), .mem_rdata(mem_rdata));
  vec_bus_model #(.SP_INIT(SP_INIT), .PC_INIT(PC_INIT)) partner (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we), .mem_space(mem_space),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .delay(delay), .iack_mode(iack_mode), .iack_vec(iack_vec),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_avec(mem_avec), .mem_rdata(mem_rdata), .rd_space(rd_space),
    .wr_prev(wr_prev), .wr_last(wr_last));

  // 250 MHz core clock
  always #2 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // bus and exception tasks
  // ****************************************
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1); // a slave that never answers is ended by the watchdog
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // raise causes (or wait on a set irq_level), follow one exception to its new pc and judge it
  task automatic run_exc(input logic [12:0] cause, input logic [7:0] vec, input logic [15:0] sr_exp);
    logic [15:0] sr_seen;
    logic        left;
    int          k;
    sr_seen = 16'h0;
    left    = 1'h0;
    k       = 0;
    cause_pulse <= cause;
    do begin
      @(posedge pclk);
      cause_pulse <= 13'h0;
      if (mem_req === 1'h1 && mem_space === 4'hF)
        irq_level <= 3'h0; // peripheral drops its request once acknowledged
      if (sr_load === 1'h1)
        sr_seen = sr_out;
      if (loop_exit === 1'h1)
        left = 1'h1;
      k++;
    end while (pc_load !== 1'h1 && k < 200);
    ssp_exp = ssp_exp - 32'h8;
    check(pc_out, vector_table_base + {22'h0, vec, 2'h0} + 32'h0100_0000);
    check({16'h0, sr_seen}, {16'h0, sr_exp});
    check({31'h0, left}, 32'h1);
    check({28'h0, rd_space}, 32'h5);
    check(wr_prev, pc_in);
    check({wr_last[31:16], 8'h0, wr_last[9:2]}, {sr_in, 8'h0, vec});
    // a second pending cause starts at once, so its own call reads the registers
    if ($countones(cause) < 2) begin
      apb(1'h0, 12'h004, 32'h0);
      check({24'h0, q[7:0]}, {24'h0, vec});
      apb(1'h0, 12'h008, 32'h0);
      check(q, ssp_exp);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, low_power_halt_instruction} = 6'h0;
    {paddr, pwdata, cause_pulse, trap_variant, irq_level, halt_wake_level} = '0;
    {delay, iack_mode, iack_vec, failures, cmp_count} = '0;
    sr_in   = 16'hC000;
    pc_in   = 32'h0000_1234;
    ssp_exp = SP_INIT;
    vector_table_base     = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'h1 && n < 100);
    check(pc_out, PC_INIT);
    check({16'h0, sr_out}, 32'h0000_2700);
    check({28'h0, rd_space}, 32'h6);
    apb(1'h0, 12'h008, 32'h0);
    check(q, SP_INIT);
    apb(1'h0, 12'h00C, 32'h0);
    check({31'h0, e}, 32'h1);
    vector_table_base = 32'h0000_2000;
    apb(1'h1, 12'h000, vector_table_base);
    apb(1'h0, 12'h000, 32'h0);
    check(q, vector_table_base);
    // every internal cause, slave pacing varied
    trap_variant <= 4'hF;
    for (int i = 0; i < 13; i++) begin
      delay <= 2'(i);
      run_exc(13'h1 << i, VECS[i], 16'h2000);
    end
    // two causes at once: lower index first, the other right after
    trap_variant <= 4'h0;
    run_exc(13'h1004, 8'h04, 16'h2000);
    run_exc(13'h0, 8'h20, 16'h2000);
    // relocated table, then interrupts by vector, autovector and spurious answer
    vector_table_base = 32'h0001_0000;
    apb(1'h1, 12'h000, vector_table_base);
    for (int i = 0; i < 4; i++) begin
      irq_level <= 3'(2 * i + 1);
      iack_mode <= (i == 3) ? 2'h1 : 2'(i % 3); // level 7 asks for its autovector
      iack_vec  <= 8'h40;
      run_exc(13'h0, i == 0 ? 8'h40 : (i == 2 ? 8'h18 : 8'(25 + 2 * i)), 16'h2000 | (16'(2 * i + 1) << 8));
    end
    // halt ignores a level below the wake level
    low_power_halt_instruction <= 1'h1;
    halt_wake_level            <= 3'h5;
    @(posedge pclk);
    low_power_halt_instruction <= 1'h0;
    irq_level                  <= 3'h3;
    repeat (10) @(posedge pclk);
    check({31'h0, halted}, 32'h1);
    irq_level <= 3'h5;
    iack_mode <= 2'h0;
    iack_vec  <= 8'hFF;
    run_exc(13'h0, 8'hFF, 16'h2500);
    check({31'h0, halted}, 32'h0);
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
endmodule
